// ==== asrp_device.sv ====
// converter end: sample fifo, conversion timing and serial result shifter
`default_nettype none

// ****************************************************
// sample fifo
// ****************************************************
module asrp_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst_n,
  // fill side
  input  wire logic [WIDTH-1:0] i_in_data,
  input  wire logic             i_in_valid,
  output var  logic             o_in_ready,
  // drain side
  output var  logic [WIDTH-1:0] o_out_data,
  output var  logic             o_out_valid,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             push;
  logic             pop;

  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign o_out_data  = mem_reg[rd_ptr_reg];
  assign o_out_valid = (count_reg != '0);

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      o_in_ready <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg  <= count_next;
      o_in_ready <= (count_next != (AW + 1)'(DEPTH));
    end
  end
endmodule : asrp_fifo

// ****************************************************
// converter end
// ****************************************************
module asrp_device #(
  parameter int RESULT_W   = asrp_pkg::RESULT_W,
  parameter int FIFO_DEPTH = asrp_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                i_ref_clk,
  input  wire logic                i_rst_n,
  // link
  asrp_link_if.device              link,
  // sampled analog input stream
  input  wire logic [RESULT_W-1:0] i_analog_input,
  input  wire logic                i_analog_valid,
  output var  logic                o_analog_ready,
  // conversion status
  output var  logic                o_conv_busy
);
  localparam int FRAME_W = RESULT_W + asrp_pkg::PAD_W;

  logic [2:0]            sync1_reg;
  logic [2:0]            sync2_reg;
  logic [2:0]            sync3_reg;
  logic                  sclk_rise;
  logic                  sclk_fall;
  logic                  cs_low;
  logic                  cs_rise;
  logic                  cs_fall;
  logic                  mk_high;
  logic                  mk_rise;
  logic                  mk_fall;
  logic                  start_evt;
  logic                  present_evt;
  logic                  sdo_reg;
  logic                  sdo_oe_reg;
  logic                  started_reg;
  logic [FRAME_W-1:0]    frame_reg;
  logic [asrp_pkg::BIT_CNT_W-1:0]  fall_cnt_reg;
  logic [asrp_pkg::CONV_CNT_W-1:0] conv_cnt_reg;
  logic [RESULT_W-1:0]   sample_hold_reg;
  logic [RESULT_W-1:0]   result_reg;
  logic [RESULT_W-1:0]   fifo_data;
  logic                  fifo_valid;

  asrp_fifo #(
    .WIDTH (RESULT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_rst_n     (i_rst_n),
    .i_in_data   (i_analog_input),
    .i_in_valid  (i_analog_valid),
    .o_in_ready  (o_analog_ready),
    .o_out_data  (fifo_data),
    .o_out_valid (fifo_valid),
    .i_out_ready (start_evt)
  );

  // ****************************************************
  // pin synchronisers, bit 0 sclk, 1 select, 2 marker
  // ****************************************************
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_reg <= 3'h6;
      sync2_reg <= 3'h6;
      sync3_reg <= 3'h6;
    end else begin
      sync1_reg <= {link.dsp_frame_marker, link.cs_n, link.sclk};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // all activity follows host clock and framing edges
  assign sclk_rise = sync2_reg[0] && !sync3_reg[0];
  assign sclk_fall = !sync2_reg[0] && sync3_reg[0];
  assign cs_low    = !sync2_reg[1];
  assign cs_rise   = sync2_reg[1] && !sync3_reg[1];
  assign cs_fall   = !sync2_reg[1] && sync3_reg[1];
  assign mk_high   = sync2_reg[2];
  assign mk_rise   = sync2_reg[2] && !sync3_reg[2];
  assign mk_fall   = !sync2_reg[2] && sync3_reg[2];

  // marker high at select fall starts at once; else marker fall starts
  assign start_evt   = !cs_rise && ((cs_fall && mk_high) ||
                       (!cs_fall && cs_low && mk_fall && sdo_oe_reg));
  // output leaves high impedance on select fall or marker rise
  assign present_evt = !cs_rise && (cs_fall || (cs_low && mk_rise));

  // ****************************************************
  // serial result shifter
  // ****************************************************
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sdo_reg      <= 1'b0;
      sdo_oe_reg   <= 1'b0;
      started_reg  <= 1'b0;
      frame_reg    <= '0;
      fall_cnt_reg <= '0;
    end else if (cs_rise) begin
      sdo_oe_reg  <= 1'b0;
      started_reg <= 1'b0;
    end else if (present_evt) begin
      // result in the upper bits, don't-care zeros below
      frame_reg    <= {result_reg, asrp_pkg::PAD_W'(0)};
      sdo_reg      <= result_reg[RESULT_W-1];
      sdo_oe_reg   <= 1'b1;
      started_reg  <= start_evt;
      fall_cnt_reg <= '0;
    end else if (start_evt) begin
      started_reg  <= 1'b1;
      fall_cnt_reg <= '0;
    end else if (started_reg && sclk_fall) begin
      if (fall_cnt_reg == asrp_pkg::BIT_CNT_W'(FRAME_W - 1)) begin
        sdo_oe_reg  <= 1'b0;
        started_reg <= 1'b0;
      end
      fall_cnt_reg <= fall_cnt_reg + 1'b1;
    end else if (started_reg && sclk_rise && fall_cnt_reg != '0) begin
      // next bit after each rising edge that follows a falling edge, stable for the next falling edge
      frame_reg <= {frame_reg[FRAME_W-2:0], 1'b0};
      sdo_reg   <= frame_reg[FRAME_W-2];
    end
  end

  assign link.sdo    = sdo_reg;
  assign link.sdo_oe = sdo_oe_reg;

  // ****************************************************
  // conversion timed by the serial clock
  // ****************************************************
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_conv_busy     <= 1'b0;
      conv_cnt_reg    <= '0;
      sample_hold_reg <= '0;
      result_reg      <= '0;
    end else if (start_evt) begin
      if (fifo_valid) begin
        sample_hold_reg <= fifo_data;
      end
      o_conv_busy  <= 1'b1;
      conv_cnt_reg <= '0;
    end else if (o_conv_busy && sclk_fall) begin
      // conversion lasts a fixed count of host clocks
      if (conv_cnt_reg == asrp_pkg::CONV_CNT_W'(asrp_pkg::CONV_SCLK_CYCLES - 1)) begin
        o_conv_busy <= 1'b0;
        result_reg  <= sample_hold_reg;
      end
      conv_cnt_reg <= conv_cnt_reg + 1'b1;
    end
  end
endmodule : asrp_device

`default_nettype wire

// ==== asrp_pkg.sv ====
// constants and types shared by both ends of the serial result port
// Function
// - device delivers twelve-bit result per sample
// - host serial clock paces the conversion
// - host makes serial clock, at most 20 MHz
// - device acts only on host clock and framing edges
// - chip select fall starts driving data line
// - data line floats until select fall/marker rise
// - result shifted out most significant bit first
// - unused frame marker is held high
// - marker high at select fall: MSB, first fall
// - marker low at select fall: MSB right away
// - select held low: MSB after marker rises
// - host may use frame marker as select
// - sixteen-bit frame, twelve result, four don't-care
// - data changes on rising, host samples falling
// - host clocks a falling edge while deselected
// - marker falling edge starts sample and conversion
`default_nettype none

package asrp_pkg;

  // ****************************************************
  // widths
  // ****************************************************
  localparam int RESULT_W   = 12;
  localparam int PAD_W      = 4;
  localparam int FRAME_W    = RESULT_W + PAD_W;
  localparam int BIT_CNT_W  = 5;
  localparam int FIFO_DEPTH = 8;

  // ****************************************************
  // timing
  // ****************************************************
  localparam int REF_CLK_MHZ     = 125;
  localparam int SCLK_MAX_MHZ    = 20;
  localparam int CONV_TIME_NS    = 1500;
  // least conversion time rounded up to whole serial clocks
  localparam int CONV_SCLK_CYCLES = (CONV_TIME_NS * SCLK_MAX_MHZ + 999) / 1000;
  localparam int CONV_CNT_W      = 6;
  localparam int SCLK_PERIOD_NS  = 80;
  localparam int SCLK_HALF_CYCLES = (SCLK_PERIOD_NS * REF_CLK_MHZ) / 2000;
  localparam int DIV_W           = 4;
  localparam int CAPTURE_LAG     = 2;

  // ****************************************************
  // host framing modes
  // ****************************************************
  typedef enum logic [1:0] {
    ASRP_MODE_CS,
    ASRP_MODE_CS_MARKER,
    ASRP_MODE_MARKER
  } asrp_mode_t;

endpackage : asrp_pkg

`default_nettype wire

// ==== asrp_link_if.sv ====
// the four-wire serial link between host and converter end
`default_nettype none

interface asrp_link_if;
  logic sclk;
  logic cs_n;
  logic dsp_frame_marker;
  logic sdo;
  logic sdo_oe;

  modport host (
    output sclk,
    output cs_n,
    output dsp_frame_marker,
    input  sdo,
    input  sdo_oe
  );

  modport device (
    input  sclk,
    input  cs_n,
    input  dsp_frame_marker,
    output sdo,
    output sdo_oe
  );
endinterface : asrp_link_if

`default_nettype wire

// ==== asrp_host.sv ====
// host end: serial clock divider, framing sequencer and result capture
`default_nettype none

module asrp_host #(
  parameter int RESULT_W = asrp_pkg::RESULT_W
) (
  // clock and reset
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_rst_n,
  // link
  asrp_link_if.host                 link,
  // request
  input  wire logic                 i_start,
  input  wire asrp_pkg::asrp_mode_t i_mode,
  output var  logic                 o_busy,
  // answer
  output var  logic [RESULT_W-1:0]  o_word,
  output var  logic                 o_word_valid
);
  localparam int FRAME_W = RESULT_W + asrp_pkg::PAD_W;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ARM,
    ST_MARK,
    ST_SHIFT,
    ST_DONE
  } asrp_hstate_t;

  asrp_hstate_t          state_reg;
  asrp_pkg::asrp_mode_t  mode_reg;
  logic [asrp_pkg::DIV_W-1:0] div_reg;
  logic                  sclk_reg;
  logic                  cs_n_reg;
  logic                  mk_reg;
  logic                  rise_evt;
  logic                  fall_evt;
  logic [asrp_pkg::CAPTURE_LAG-1:0] lag_reg;
  logic                  sdo_s1_reg;
  logic                  sdo_s2_reg;
  logic [FRAME_W-1:0]    shift_reg;
  logic [FRAME_W-1:0]    shift_next;
  logic [asrp_pkg::BIT_CNT_W-1:0] bit_cnt_reg;

  // ****************************************************
  // free-running serial clock divider
  // ****************************************************
  assign rise_evt = (div_reg == asrp_pkg::DIV_W'(asrp_pkg::SCLK_HALF_CYCLES - 1)) && !sclk_reg;
  assign fall_evt = (div_reg == asrp_pkg::DIV_W'(asrp_pkg::SCLK_HALF_CYCLES - 1)) && sclk_reg;

  // clock keeps running while deselected so falling edges occur
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_reg  <= '0;
      sclk_reg <= 1'b0;
    end else if (div_reg == asrp_pkg::DIV_W'(asrp_pkg::SCLK_HALF_CYCLES - 1)) begin
      div_reg  <= '0;
      sclk_reg <= !sclk_reg;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // ****************************************************
  // data input synchroniser and capture delay
  // ****************************************************
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sdo_s1_reg <= 1'b0;
      sdo_s2_reg <= 1'b0;
      lag_reg    <= '0;
    end else begin
      sdo_s1_reg <= link.sdo;
      sdo_s2_reg <= sdo_s1_reg;
      lag_reg    <= {lag_reg[asrp_pkg::CAPTURE_LAG-2:0], fall_evt};
    end
  end

  assign shift_next = {shift_reg[FRAME_W-2:0], sdo_s2_reg};

  // ****************************************************
  // framing sequencer
  // ****************************************************
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg    <= ST_IDLE;
      mode_reg     <= asrp_pkg::ASRP_MODE_CS;
      cs_n_reg     <= 1'b1;
      mk_reg       <= 1'b1;
      o_busy       <= 1'b0;
      o_word       <= '0;
      o_word_valid <= 1'b0;
      shift_reg    <= '0;
      bit_cnt_reg  <= '0;
    end else begin
      o_word_valid <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          if (i_start && !o_busy) begin
            o_busy   <= 1'b1;
            mode_reg <= i_mode;
          end else if (o_busy && rise_evt) begin
            bit_cnt_reg <= '0;
            if (mode_reg != asrp_pkg::ASRP_MODE_MARKER && !cs_n_reg) begin
              // select left low by marker framing: deselect one clock period first
              cs_n_reg <= 1'b1;
              mk_reg   <= 1'b1;
            end else if (mode_reg == asrp_pkg::ASRP_MODE_MARKER && cs_n_reg) begin
              // lower select once with marker low, then keep it low
              cs_n_reg <= 1'b0;
              mk_reg   <= 1'b0;
            end else begin
              unique case (mode_reg)
                asrp_pkg::ASRP_MODE_CS: begin
                  cs_n_reg  <= 1'b0; // marker idles high
                  mk_reg    <= 1'b1;
                  state_reg <= ST_SHIFT;
                end
                asrp_pkg::ASRP_MODE_CS_MARKER: begin
                  cs_n_reg  <= 1'b0;
                  mk_reg    <= 1'b0;
                  state_reg <= ST_ARM;
                end
                asrp_pkg::ASRP_MODE_MARKER: begin
                  cs_n_reg  <= 1'b0; // select held low, marker frames
                  mk_reg    <= 1'b1;
                  state_reg <= ST_MARK;
                end
                default: begin
                  o_busy <= 1'b0;
                end
              endcase
            end
          end
        end
        ST_ARM: begin
          if (rise_evt) begin
            mk_reg    <= 1'b1;
            state_reg <= ST_MARK;
          end
        end
        ST_MARK: begin
          if (rise_evt) begin
            mk_reg    <= 1'b0;
            state_reg <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          // bits captured after falling edges, MSB first
          if (lag_reg[asrp_pkg::CAPTURE_LAG-1]) begin
            shift_reg   <= shift_next;
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
            if (bit_cnt_reg == asrp_pkg::BIT_CNT_W'(FRAME_W - 1)) begin
              o_word       <= shift_next[FRAME_W-1:asrp_pkg::PAD_W];
              o_word_valid <= 1'b1;
              state_reg    <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          if (rise_evt) begin
            cs_n_reg  <= (mode_reg == asrp_pkg::ASRP_MODE_MARKER) ? 1'b0 : 1'b1;
            mk_reg    <= (mode_reg == asrp_pkg::ASRP_MODE_CS) ? 1'b1 : 1'b0;
            o_busy    <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  assign link.sclk             = sclk_reg;
  assign link.cs_n             = cs_n_reg;
  assign link.dsp_frame_marker = mk_reg;
endmodule : asrp_host

`default_nettype wire

// ==== asrp_link_checker.sv ====
// concurrent checks on the serial link between host and converter end
`default_nettype none

module asrp_link_checker (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic dsp_frame_marker,
  input wire logic sdo,
  input wire logic sdo_oe
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  // ****************************************************
  // data line drive and release
  // ****************************************************
  cs_fall_drive_a: assert property (
    $fell(cs_n) && dsp_frame_marker |-> ##[2:6] sdo_oe)
    else $error("data line not driven after select fall");
  cs_low_marker_a: assert property (
    $fell(cs_n) && !dsp_frame_marker |-> ##[2:6] sdo_oe)
    else $error("data line not driven with marker low");
  marker_rise_drive_a: assert property (
    $rose(dsp_frame_marker) && !cs_n |-> ##[2:6] sdo_oe)
    else $error("data line not driven after marker rise");
  oe_needs_select_a: assert property (
    $rose(sdo_oe) |-> !$past(cs_n, 3))
    else $error("data line driven without select");
  cs_rise_float_a: assert property (
    $rose(cs_n) |-> ##[1:6] !sdo_oe)
    else $error("data line still driven after deselect");

  // ****************************************************
  // bit timing and serial clock
  // ****************************************************
  shift_on_rise_a: assert property (
    sdo_oe && $past(sdo_oe) && $changed(sdo) |-> sclk)
    else $error("data changed while serial clock low");
  hold_at_fall_a: assert property (
    $fell(sclk) && sdo_oe && $past(sdo_oe, 2) |-> $stable(sdo)[*2])
    else $error("data moved around serial clock fall");
  sclk_shape_a: assert property (
    $rose(sclk) |-> sclk[*5] ##1 !sclk[*5])
    else $error("serial clock period wrong");
  idle_clock_a: assert property (
    $rose(cs_n) |-> ##[1:12] (cs_n && $fell(sclk)))
    else $error("no clock fall while deselected");
endmodule : asrp_link_checker

`default_nettype wire

// ==== adc_serial_result_port_tb.sv ====
// self-checking bench: host and converter end joined over the serial link
`default_nettype none

module adc_serial_result_port_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                 i_ref_clk;
  logic                 i_rst_n;
  logic                 i_start;
  asrp_pkg::asrp_mode_t i_mode;
  logic                 o_busy;
  logic [11:0]          o_word;
  logic                 o_word_valid;
  logic [11:0]          i_analog_input;
  logic                 i_analog_valid;
  logic                 o_analog_ready;
  logic                 o_conv_busy;
  logic [15:0]          exp_q[$];
  logic [11:0]          fifo_model[$];
  logic [11:0]          conv_model;
  logic [15:0]          wire_shift;
  int                   wire_cnt;
  int                   fail_count;
  int                   samples_checked;
  int                   cycle_count = 0;

  asrp_link_if link ();
  asrp_link_if link_b ();

  asrp_host u_asrp_host (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .link(link.host), .i_start(i_start),
    .i_mode(i_mode), .o_busy(o_busy), .o_word(o_word), .o_word_valid(o_word_valid));
  asrp_device u_asrp_device (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .link(link.device),
    .i_analog_input(i_analog_input), .i_analog_valid(i_analog_valid), .o_analog_ready(o_analog_ready),
    .o_conv_busy(o_conv_busy));
  // second converter end, driven directly to abort a frame
  asrp_device u_asrp_device_b (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .link(link_b.device),
    .i_analog_input(12'h000), .i_analog_valid(1'b0), .o_analog_ready(), .o_conv_busy());
  asrp_link_checker u_asrp_link_checker (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .sclk(link.sclk),
    .cs_n(link.cs_n), .dsp_frame_marker(link.dsp_frame_marker), .sdo(link.sdo), .sdo_oe(link.sdo_oe));

  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end

  // ****************************************************
  // tasks
  // ****************************************************
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : check

  task automatic stop_test;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  task automatic run_frame(input asrp_pkg::asrp_mode_t m);
    exp_q.push_back({conv_model, 4'h0});
    if (fifo_model.size() != 0) conv_model = fifo_model.pop_front();
    i_mode = m;
    i_start = 1'b1;
    @(negedge i_ref_clk);
    i_start = 1'b0;
    repeat (20) @(negedge i_ref_clk);
    // a start while busy must be ignored
    i_start = 1'b1;
    @(negedge i_ref_clk);
    i_start = 1'b0;
    for (int n = 0; n < 600 && o_busy !== 1'b0; n++) @(negedge i_ref_clk);
    for (int n = 0; n < 600 && o_conv_busy !== 1'b0; n++) @(negedge i_ref_clk);
  endtask : run_frame

  task automatic sclk_b_pulse;
    repeat (5) @(negedge i_ref_clk);
    link_b.sclk = 1'b1;
    repeat (5) @(negedge i_ref_clk);
    link_b.sclk = 1'b0;
  endtask : sclk_b_pulse

  // ****************************************************
  // monitors
  // ****************************************************
  always @(posedge link.sdo_oe) wire_cnt = 0;
  always @(negedge link.dsp_frame_marker) wire_cnt = 0;

  always @(negedge link.sclk) begin
    if (link.sdo_oe === 1'b1 && wire_cnt < 16) begin
      wire_shift = {wire_shift[14:0], link.sdo};
      wire_cnt++;
      if (wire_cnt == 16) check(wire_shift, exp_q.size() != 0 ? exp_q[0] : 16'hxxxx, "wire frame");
    end
  end

  always @(negedge i_ref_clk) begin
    if (o_word_valid === 1'b1) begin
      if (exp_q.size() == 0) check(16'h0001, 16'h0000, "unexpected word");
      else check({o_word, 4'h0}, exp_q.pop_front(), "captured word");
    end
  end

  always @(posedge i_ref_clk) begin
    cycle_count <= cycle_count + 1;
    if (cycle_count == 30000) begin
      fail_count++;
      stop_test();
    end
  end

  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    i_rst_n = 1'b0;
    i_start = 1'b0;
    i_mode = asrp_pkg::ASRP_MODE_CS;
    i_analog_input = 12'h000;
    i_analog_valid = 1'b0;
    link_b.sclk = 1'b0;
    link_b.cs_n = 1'b1;
    link_b.dsp_frame_marker = 1'b1;
    conv_model = 12'h000;
    fail_count = 0;
    samples_checked = 0;
    wire_cnt = 0;
    repeat (2) @(negedge i_ref_clk);
    i_rst_n = 1'b1;
    void'($urandom(42495));
    // fill the sample fifo until it refuses
    i_analog_valid = 1'b1;
    for (int i = 0; i < 8; i++) begin
      i_analog_input = 12'($urandom());
      fifo_model.push_back(i_analog_input);
      @(negedge i_ref_clk);
    end
    i_analog_input = 12'hfff;
    repeat (2) @(negedge i_ref_clk);
    check({15'h0000, o_analog_ready}, 16'h0000, "fifo full");
    i_analog_valid = 1'b0;
    // drain through every framing mode, two frames past empty
    for (int i = 0; i < 10; i++) run_frame(asrp_pkg::asrp_mode_t'(i % 3));
    check({15'h0000, o_analog_ready}, 16'h0001, "fifo drained");
    check(16'(exp_q.size()), 16'h0000, "words outstanding");
    // abort a frame on the second converter end
    sclk_b_pulse();
    link_b.cs_n = 1'b0;
    repeat (3) sclk_b_pulse();
    check({15'h0000, link_b.sdo_oe}, 16'h0001, "driven after select");
    link_b.cs_n = 1'b1;
    repeat (8) @(negedge i_ref_clk);
    check({15'h0000, link_b.sdo_oe}, 16'h0000, "float after abort");
    sclk_b_pulse();
    stop_test();
  end
endmodule : adc_serial_result_port_tb

`default_nettype wire
